// ### core/dio_ctrl.v
// digital line state control and analog output code/enable control
`timescale 1ns/1ps
`include "dio_defines.vh"
// Functional notes
// - lines 0-7 flex, 8-15 extended, 16-19 control group, 20-22 mux select
// - every line is input, output-high or output-low, set independently
// - input weakly pulled up; output-high drives 3.3 V; output-low drives ground
// - power-up line states user configurable; factory default is all inputs
// - lines hold factory default about 100 ms before user power-up state
// - line n maps to bit n; direction 1 is output, 0 input
// - flex lines default to digital i/o, may go to 6 timers, 2 counters
// - mux lines are ordinary lines and also drive external mux control
// - one transfer command both updates and reads back all line states
// - two analog channels, each set by a 12-bit code
// - one shared enable; disabled means both outputs high impedance
// - analog power-up enable and code configurable; factory enabled at minimum
// - analog outputs hold factory default about 100 ms after power-up
module dio_ctrl #(
   parameter [31:0] HOLD_CYCLES = `DIO_HOLD_CYCLES
) (
   // clock and reset
   input wire i_clock,
   input wire i_arst_n,
   // user power-up settings, from non-volatile storage
   input wire [22:0] i_pwrup_dir,
   input wire [22:0] i_pwrup_out,
   input wire i_pwrup_dac_en,
   input wire [15:0] i_pwrup_dac0,
   input wire [15:0] i_pwrup_dac1,
   // transfer command: update and read back all lines
   input wire i_xfer_req,
   input wire [22:0] i_xfer_dir_mask,
   input wire [22:0] i_xfer_dir,
   input wire [22:0] i_xfer_out_mask,
   input wire [22:0] i_xfer_out,
   output reg o_xfer_ack,
   output reg [22:0] o_xfer_state,
   output reg [22:0] o_xfer_dir,
   // analog output commands
   input wire i_dac_wr,
   input wire i_dac_sel,
   input wire [15:0] i_dac_code,
   input wire i_dac_en_wr,
   input wire i_dac_en,
   // flex line function select: 1 hands line to timer/counter
   input wire [7:0] i_flex_func_sel,
   input wire [7:0] i_flex_func_out,
   input wire [7:0] i_flex_func_oe,
   // digital line pins
   input wire [22:0] i_line_in,
   output reg [22:0] o_line_out,
   output reg [22:0] o_line_oe,
   output reg [22:0] o_line_pullup,
   output reg [2:0] o_mux_select_line,
   output reg [7:0] o_flex_func_in,
   // converter outputs
   output reg [11:0] o_dac0_code,
   output reg [11:0] o_dac1_code,
   output reg o_dac_en,
   output reg o_hold_active
);
   // ****************************************
   // states
   // ****************************************
   localparam [1:0] ST_HOLD = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;
   reg [1:0] state_r;
   reg [31:0] hold_cnt_r;
   reg [22:0] dir_r;
   reg [22:0] out_r;
   reg [11:0] dac0_r;
   reg [11:0] dac1_r;
   reg dac_en_r;
   wire [22:0] pin_sync;
   wire [22:0] dir_nxt;
   wire [22:0] out_nxt;
   wire run_w;
   // ****************************************
   // pin synchroniser
   // ****************************************
   // pins are asynchronous; two flops before any logic reads them
   dio_sync_bank u_sync (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_async(i_line_in),
      .o_sync(pin_sync)
   );
   // ****************************************
   // code clamp
   // ****************************************
   // clamp out-of-range codes at the top; unsigned so no lower clamp needed
   function [11:0] clamp_code;
      input [15:0] c;
      begin
         if (c > `DIO_CODE_MAX)
            clamp_code = {`DIO_CODE_W{1'b1}};
         else
            clamp_code = c[11:0];
      end
   endfunction
   // ****************************************
   // power-up hold and run
   // ****************************************
   // user settings only sampled after hold, never under reset
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= ST_HOLD;
         hold_cnt_r <= 32'h00000000;
         dir_r <= `DIO_FACT_DIR;
         out_r <= `DIO_FACT_OUT;
         dac0_r <= `DIO_CODE_MIN;
         dac1_r <= `DIO_CODE_MIN;
         dac_en_r <= `DIO_FACT_DAC_EN;
      end else begin
         case (state_r)
            ST_HOLD: begin
               // commands ignored while factory defaults held
               if (hold_cnt_r >= HOLD_CYCLES - 32'h00000001) begin
                  state_r <= ST_RUN;
                  dir_r <= i_pwrup_dir;
                  out_r <= i_pwrup_out;
                  dac_en_r <= i_pwrup_dac_en;
                  dac0_r <= clamp_code(i_pwrup_dac0);
                  dac1_r <= clamp_code(i_pwrup_dac1);
               end else begin
                  // counter stops at terminal count; only reset starts the hold again
                  hold_cnt_r <= hold_cnt_r + 32'h00000001;
               end
            end
            ST_RUN: begin
               if (i_xfer_req) begin
                  dir_r <= dir_nxt;
                  out_r <= out_nxt;
               end
               if (i_dac_wr) begin
                  if (i_dac_sel)
                     dac1_r <= clamp_code(i_dac_code);
                  else
                     dac0_r <= clamp_code(i_dac_code);
               end
               if (i_dac_en_wr)
                  dac_en_r <= i_dac_en;
            end
            default: state_r <= ST_HOLD;
         endcase
      end
   end
   // masked per-bit update, line n at bit n
   assign dir_nxt = (dir_r & ~i_xfer_dir_mask) | (i_xfer_dir & i_xfer_dir_mask);
   assign out_nxt = (out_r & ~i_xfer_out_mask) | (i_xfer_out & i_xfer_out_mask);
   assign run_w = (state_r == ST_RUN);
   // ****************************************
   // pin drive
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < `DIO_NUM_LINES; g = g + 1) begin : g_line
         wire fn;
         wire oe;
         wire lvl;
         if (g <= `DIO_FLEX_HI) begin : g_flex
            // timer/counter may not take a line during the factory hold
            assign fn = i_flex_func_sel[g] & run_w;
         end else begin : g_plain
            assign fn = 1'b0;
         end
         if (g <= `DIO_FLEX_HI) begin : g_fsrc
            assign oe = fn ? i_flex_func_oe[g] : dir_r[g];
            assign lvl = fn ? i_flex_func_out[g] : out_r[g];
         end else begin : g_dsrc
            assign oe = dir_r[g];
            assign lvl = out_r[g];
         end
         always @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               o_line_oe[g] <= 1'b0;
               o_line_out[g] <= 1'b0;
               o_line_pullup[g] <= 1'b1;
            end else begin
               o_line_oe[g] <= oe;
               o_line_out[g] <= lvl;
               o_line_pullup[g] <= ~oe;
            end
         end
      end
   endgenerate
   // ****************************************
   // outputs
   // ****************************************
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_xfer_ack <= 1'b0;
         o_xfer_state <= 23'h7FFFFF;
         o_xfer_dir <= 23'h000000;
         o_mux_select_line <= 3'h0;
         o_flex_func_in <= 8'hFF;
         o_dac0_code <= `DIO_CODE_MIN;
         o_dac1_code <= `DIO_CODE_MIN;
         o_dac_en <= `DIO_FACT_DAC_EN;
         o_hold_active <= 1'b1;
      end else begin
         // requests during the hold vanish without an answer
         o_xfer_ack <= i_xfer_req && run_w;
         if (i_xfer_req && run_w) begin
            // output lines report the driven level, inputs the pin
            o_xfer_state <= (pin_sync & ~dir_nxt) | (out_nxt & dir_nxt);
            o_xfer_dir <= dir_nxt;
         end
         o_mux_select_line <= out_r[`DIO_MUX_HI:`DIO_MUX_LO];
         o_flex_func_in <= pin_sync[`DIO_FLEX_HI:`DIO_FLEX_LO];
         // codes stay held while disabled so re-enable restores them
         o_dac0_code <= dac0_r;
         o_dac1_code <= dac1_r;
         o_dac_en <= dac_en_r;
         o_hold_active <= (state_r == ST_HOLD);
      end
   end
endmodule // dio_ctrl

// ### core/dio_defines.vh
// constants for the digital line and analog output control block
`ifndef DIO_DEFINES_VH
`define DIO_DEFINES_VH
`define DIO_NUM_LINES 23
`define DIO_FLEX_LO 0
`define DIO_FLEX_HI 7
`define DIO_EXT_LO 8
`define DIO_EXT_HI 15
`define DIO_CTRL_LO 16
`define DIO_CTRL_HI 19
`define DIO_MUX_LO 20
`define DIO_MUX_HI 22
`define DIO_CODE_W 12
`define DIO_CODE_IN_W 16
`define DIO_CODE_MAX 16'h0FFF
`define DIO_CODE_MIN 12'h000
`define DIO_CLK_MHZ 200
`define DIO_HOLD_MS 100
`define DIO_HOLD_CYCLES (`DIO_HOLD_MS * 1000 * `DIO_CLK_MHZ)
`define DIO_TMR_FUNCS 6
`define DIO_CNT_FUNCS 2
`define DIO_FACT_DIR 23'h000000
`define DIO_FACT_OUT 23'h000000
`define DIO_FACT_DAC_EN 1'b1
`endif

// ### core/dio_sync_bank.v
// two-stage synchroniser bank for the digital line pin levels
`timescale 1ns/1ps
module dio_sync_bank (
   // clock and reset
   input wire i_clock,
   input wire i_arst_n,
   // asynchronous pin levels
   input wire [22:0] i_async,
   // synchronised levels
   output reg [22:0] o_sync
);
   reg [22:0] meta_r;
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_r <= 23'h7FFFFF;
         o_sync <= 23'h7FFFFF;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // dio_sync_bank

// ### dv/digital_io_and_dac_output_control_bench.sv
// testbench for the digital line and analog output control
`timescale 1ns/1ps
module digital_io_and_dac_output_control_bench;
   reg clk = 1'b0, rst_n = 1'b0, req = 1'b0, dwr = 1'b0, dsel = 1'b0, ewr = 1'b0, en = 1'b0;
   reg [22:0] pw_dir = 23'h700005, pw_out = 23'h400001, dm = 23'h0, dv = 23'h0, om = 23'h0;
   reg [22:0] ov = 23'h0, xdrv = 23'h0, xlvl = 23'h0, b;
   reg [15:0] code = 16'h0000;
   reg [7:0] fsel = 8'h00, fout = 8'h00, foe = 8'h00;
   wire ack, den, hold;
   wire [22:0] st, lo, loe, lpu, pin, xd;
   wire [2:0] mux;
   wire [7:0] ffin;
   wire [11:0] c0, c1;
   integer mismatches = 0, checks_done = 0, cyc = 0, n;
   dio_ctrl #(.HOLD_CYCLES(32'h10)) uut (.i_clock(clk), .i_arst_n(rst_n), .i_pwrup_dir(pw_dir),
      .i_pwrup_out(pw_out), .i_pwrup_dac_en(1'b0), .i_pwrup_dac0(16'h1234),
      .i_pwrup_dac1(16'h0800), .i_xfer_req(req), .i_xfer_dir_mask(dm), .i_xfer_dir(dv),
      .i_xfer_out_mask(om), .i_xfer_out(ov), .o_xfer_ack(ack), .o_xfer_state(st),
      .o_xfer_dir(xd), .i_dac_wr(dwr), .i_dac_sel(dsel), .i_dac_code(code), .i_dac_en_wr(ewr),
      .i_dac_en(en), .i_flex_func_sel(fsel), .i_flex_func_out(fout), .i_flex_func_oe(foe),
      .i_line_in(pin), .o_line_out(lo), .o_line_oe(loe), .o_line_pullup(lpu),
      .o_mux_select_line(mux), .o_flex_func_in(ffin), .o_dac0_code(c0), .o_dac1_code(c1),
      .o_dac_en(den), .o_hold_active(hold));
   dio_pin_model pins (.i_line_out(lo), .i_line_oe(loe), .i_line_pullup(lpu),
      .i_ext_drive(xdrv), .i_ext_level(xlvl), .o_pin(pin));
   always #2.5 clk = ~clk;
   task chk(input [22:0] got, input [22:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task step;
      begin
         @(posedge clk);
         #1;
      end
   endtask
   // one transfer; returns with lines updated and released pins through the synchroniser
   task xfer(input [22:0] a, input [22:0] d, input [22:0] m, input [22:0] o);
      begin
         dm = a; dv = d; om = m; ov = o; req = 1'b1;
         step;
         req = 1'b0;
         chk({22'h0, ack}, 23'h1);
         step;
         repeat (2) step;
      end
   endtask
   // raw converter codes only, no scaling on this side
   task dac(input w, input s, input [15:0] v, input e_w, input e);
      begin
         dwr = w; dsel = s; code = v; ewr = e_w; en = e;
         step;
         dwr = 1'b0; ewr = 1'b0;
         step;
      end
   endtask
   task complete_run;
      begin
         $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         mismatches = mismatches + 1;
         complete_run;
      end
   end
   initial begin
      repeat (3) step;
      rst_n = 1'b1;
      step;
      req = 1'b1; // must be ignored while held
      fsel = 8'h01;
      foe = 8'h01;
      step;
      req = 1'b0;
      chk({22'h0, ack}, 23'h0);
      chk(loe, 23'h0);
      chk({10'h0, den, c0}, {11'h1, 12'h000});
      for (n = 0; n < 40 && hold === 1'b1; n = n + 1) step;
      fsel = 8'h00;
      repeat (2) step;
      chk(loe, pw_dir);
      chk(lo & pw_dir, pw_out & pw_dir);
      chk({10'h0, den, c0}, {11'h0, 12'hFFF});
      chk({11'h0, c1}, 23'h000800);
      xfer(23'h7FFFFF, 23'h0, 23'h7FFFFF, 23'h0);
      for (n = 0; n < 23; n = n + 1) begin
         b = 23'h1 << n;
         xfer(b, 23'h7FFFFF, b, 23'h7FFFFF);
         chk(loe, b);
         chk(xd, b);
         chk(st, 23'h7FFFFF);
         xfer(23'h0, 23'h0, b, 23'h0);
         chk(st, ~b);
         chk(lpu, ~b);
         xfer(b, 23'h0, 23'h0, 23'h0);
         chk(loe, 23'h0);
      end
      xfer(23'h700000, 23'h700000, 23'h700000, 23'h500000);
      step;
      chk({20'h0, mux}, 23'h5);
      xfer(23'h700000, 23'h0, 23'h0, 23'h0);
      xdrv = 23'h000202;
      fsel = 8'h01; fout = 8'h01; foe = 8'h01;
      repeat (4) step;
      xfer(23'h0, 23'h0, 23'h0, 23'h0);
      chk(st, 23'h7FFDFD);
      chk(loe & 23'hFF, 23'h1);
      chk({15'h0, ffin}, 23'hFD);
      dac(1'b1, 1'b0, 16'h0456, 1'b0, 1'b0);
      chk({11'h0, c0}, 23'h456);
      dac(1'b1, 1'b0, 16'hFFFF, 1'b0, 1'b0);
      chk({11'h0, c0}, 23'hFFF);
      dac(1'b1, 1'b1, 16'h0ABC, 1'b1, 1'b1);
      chk({10'h0, den, c1}, {11'h1, 12'hABC});
      dac(1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
      chk({den, c0, 10'h0}, {1'b0, 12'hFFF, 10'h0});
      dac(1'b1, 1'b0, 16'h0123, 1'b0, 1'b0);
      dac(1'b0, 1'b0, 16'h0000, 1'b1, 1'b1);
      chk({den, c0, 10'h0}, {1'b1, 12'h123, 10'h0});
      chk({11'h0, c1}, 23'hABC);
      complete_run;
   end
endmodule // digital_io_and_dac_output_control_bench
bind dio_ctrl dio_ctrl_chk chk_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
   .i_xfer_req(i_xfer_req), .i_dac_wr(i_dac_wr), .i_dac_sel(i_dac_sel),
   .i_dac_code(i_dac_code), .i_dac_en_wr(i_dac_en_wr), .i_dac_en(i_dac_en),
   .o_xfer_ack(o_xfer_ack), .o_xfer_dir(o_xfer_dir), .o_line_oe(o_line_oe),
   .o_line_pullup(o_line_pullup), .o_dac0_code(o_dac0_code), .o_dac1_code(o_dac1_code),
   .o_dac_en(o_dac_en), .o_hold_active(o_hold_active));

// ### dv/dio_ctrl_chk.sv
// port assertions for the line and analog output control
`timescale 1ns/1ps
module dio_ctrl_chk (
   // clock and reset
   input wire i_clock,
   input wire i_arst_n,
   // commands
   input wire i_xfer_req,
   input wire i_dac_wr,
   input wire i_dac_sel,
   input wire [15:0] i_dac_code,
   input wire i_dac_en_wr,
   input wire i_dac_en,
   // outputs
   input wire o_xfer_ack,
   input wire [22:0] o_xfer_dir,
   input wire [22:0] o_line_oe,
   input wire [22:0] o_line_pullup,
   input wire [11:0] o_dac0_code,
   input wire [11:0] o_dac1_code,
   input wire o_dac_en,
   input wire o_hold_active
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   wire run = !o_hold_active;
   a_pull_inverse: assert property (
      o_line_pullup == ~o_line_oe) else $error("pull-up not opposite of drive");
   a_hold_factory: assert property (
      o_hold_active |-> o_line_oe == 23'h0 && o_dac_en && o_dac0_code == 12'h000)
      else $error("factory state lost during hold");
   a_hold_refuse: assert property (
      o_hold_active |-> !o_xfer_ack) else $error("ack during hold");
   a_no_ack_idle: assert property (
      !i_xfer_req |=> !o_xfer_ack) else $error("ack without request");
   a_dir_apply: assert property (
      o_xfer_ack |=> o_line_oe[22:8] == $past(o_xfer_dir[22:8])) else $error("dir not applied");
   a_dac0_write: assert property (
      run && i_dac_wr && !i_dac_sel |-> ##2 o_dac0_code == ($past(i_dac_code, 2) > 16'h0FFF ?
      12'hFFF : $past(i_dac_code[11:0], 2))) else $error("channel 0 code wrong");
   a_dac1_write: assert property (
      run && i_dac_wr && i_dac_sel |-> ##2 o_dac1_code == ($past(i_dac_code, 2) > 16'h0FFF ?
      12'hFFF : $past(i_dac_code[11:0], 2))) else $error("channel 1 code wrong");
   a_en_shared: assert property (
      run && i_dac_en_wr |-> ##2 o_dac_en == $past(i_dac_en, 2)) else $error("enable wrong");
   a_code_kept: assert property (
      run && $past(run) && $past(run, 2) && !$past(i_dac_wr) && !$past(i_dac_wr, 2) |->
      $stable(o_dac0_code) && $stable(o_dac1_code)) else $error("code changed unasked");
endmodule // dio_ctrl_chk

// ### dv/dio_pin_model.sv
// pin level model of the wiring outside the digital lines
`timescale 1ns/1ps
module dio_pin_model (
   // device drive
   input wire [22:0] i_line_out,
   input wire [22:0] i_line_oe,
   input wire [22:0] i_line_pullup,
   // external source, drive 1 = source active
   input wire [22:0] i_ext_drive,
   input wire [22:0] i_ext_level,
   // resolved level
   output wire [22:0] o_pin
);
   // device drive wins; an undriven input floats up to the pull-up level
   assign o_pin = (i_line_oe & i_line_out) | (~i_line_oe & i_ext_drive & i_ext_level) |
      (~i_line_oe & ~i_ext_drive & i_line_pullup);
endmodule // dio_pin_model
